/* File: radio_sensor_pkg.sv */
// Constants and carrier types for the radio sensor value decoder.
// Assumes telegrams arrive already demodulated, on the core clock domain.
package radio_sensor_pkg;

	localparam int NUM_SLOTS = 6;
	localparam logic [2:0] SLOT_IDX_ONE = 3'h0;
	localparam logic [2:0] SLOT_IDX_SIX = 3'h5;
	localparam logic [15:0] SLOT_RESET = 16'h0000;
	localparam logic [2:0] MSG_COUNT_MAX = 3'h5;

	localparam logic [7:0] ORG_ONE_BYTE = 8'hd5;
	localparam logic [7:0] ORG_FOUR_BYTE = 8'ha5;
	localparam int LEARN_BIT = 3;

	localparam logic [5:0] FN_CONTACT = 6'h00;
	localparam logic [5:0] FN_UNIVERSAL = 6'h3f;
	localparam logic [5:0] FN_TEMP = 6'h02;
	localparam logic [5:0] FN_TEMP_HUM = 6'h04;
	localparam logic [5:0] FN_PRESSURE = 6'h05;
	localparam logic [5:0] FN_LIGHT = 6'h06;
	localparam logic [5:0] FN_OCCUPANCY = 6'h07;
	localparam logic [6:0] TY_UNIVERSAL = 7'h7f;
	localparam logic [6:0] TY_TEMP_LO_FIRST = 7'h01;
	localparam logic [6:0] TY_TEMP_LO_LAST = 7'h0b;
	localparam logic [6:0] TY_TEMP_HI_FIRST = 7'h10;
	localparam logic [6:0] TY_TEMP_HI_LAST = 7'h1b;
	localparam logic [6:0] TY_TEMP_FINE_A = 7'h20;
	localparam logic [6:0] TY_TEMP_FINE_B = 7'h30;

	// Scaled value bounds; temperatures in tenths of a degree
	localparam int TEMP_LO_BASE = -400;
	localparam int TEMP_HI_BASE = -600;
	localparam int TEMP_STEP = 100;
	localparam int TEMP_LO_SPAN = 400;
	localparam int TEMP_HI_SPAN = 800;
	localparam int TEMP_A_BASE = -100;
	localparam int TEMP_A_SPAN = 512;
	localparam int TEMP_B_BASE = -400;
	localparam int TEMP_B_SPAN = 1023;
	localparam int TH1_SPAN = 400;
	localparam int TH2_BASE = -200;
	localparam int TH_SPAN = 800;
	localparam int HUM_SPAN = 1000;
	localparam int PRESS_BASE = 500;
	localparam int PRESS_SPAN = 650;
	localparam int LUX_HI_BASE = 60;
	localparam int LUX_HI_SPAN = 5940;
	localparam int LUX_LO_BASE = 30;
	localparam int LUX_LO_SPAN = 2970;
	localparam int LUX_DIV = 10;
	localparam int STORE_SPAN = 100;
	localparam int FULL_8 = 255;
	localparam int FULL_250 = 250;
	localparam int FULL_10 = 1023;
	localparam int FULL_4 = 15;
	localparam int VOLT100_SPAN = 510;
	localparam int VOLT10_SPAN = 50;

	typedef struct packed {
		logic [7:0] org;
		logic [31:0] data;
	} telegram_t;

	typedef struct packed {
		logic [7:0] org;
		logic [5:0] func;
		logic [6:0] ptype;
	} equipment_profile_t;

	typedef enum logic [3:0] {
		K_NONE, K_CONTACT, K_RAW, K_TEMP_LO, K_TEMP_HI, K_TEMP_A, K_TEMP_B,
		K_TH1, K_TH2, K_TH3, K_PRESS, K_LIGHT1, K_LIGHT4, K_OCC1, K_OCC2
	} decode_kind_t;

endpackage

/* File: radio_sensor_value_decoder.sv */
// Per-channel decoder: radio telegram to six signed 16-bit value slots.
// Assumes telegram strobe, profile select and read port share core_clk.
//
// How it works
// R1: Telegrams whose organisation code differs from the channel's are ignored.
// R2: Contact profile puts contact state, 0 open 1 closed, in slot one.
// R3: Contact profile shifts older states through slots two to five.
// R4: Slot six counts contact telegrams since slot one was read, max five.
// R5: Basic temperature profiles give degrees times ten over their range.
// R6: Fine temperature variants scale -10..41.2 and -40..62.3 degrees by ten.
// R7: Temperature/humidity gives temperature and humidity times ten, slots 1-2.
// R8: First two humidity variants flag temperature sensor presence in slot 3.
// R9: Third humidity variant: ten-bit temperature, event/heartbeat in slot 3.
// R10: Pressure 500-1150 hPa, telegram type, sensor availability in slots 1-3.
// R11: Wide light: supply x100, lux divided by ten, range flag.
// R12: Storage light: temperature, lux divided by ten, storage percent.
// R13: Storage light: slots four and five flag valid temperature and storage.
// R14: First occupancy: motion, supply x10, supply support flag.
// R15: Second occupancy: one on motion, zero when uncertain.
// R16: Negative readings are stored as 16-bit two's complement.
`timescale 1ns/10ps
module radio_sensor_value_decoder
	import radio_sensor_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic tel_valid,
	input wire telegram_t tel,
	input wire equipment_profile_t equipment_profile,
	input wire logic rd_en,
	input wire logic [2:0] rd_idx,
	output logic [15:0] rd_data_q,
	output logic rd_valid_q
);

	initial begin
		if (NUM_SLOTS != 6) $error("six value slots are required");
	end

	function automatic logic [15:0] lin(int base, int raw, int span, int full);
		int v;
		v = base + (raw * span) / full;
		return 16'(v);
	endfunction

	function automatic decode_kind_t kind_of(equipment_profile_t p);
		decode_kind_t k;
		k = K_NONE;
		if (p.org == ORG_ONE_BYTE) begin
			if (p.func == FN_CONTACT && p.ptype == 7'h01)
				k = K_CONTACT;
			else if (p.func == FN_UNIVERSAL && p.ptype == TY_UNIVERSAL)
				k = K_RAW;
		end else if (p.org == ORG_FOUR_BYTE) begin
			unique case (p.func)
				FN_TEMP: begin
					if (p.ptype >= TY_TEMP_LO_FIRST && p.ptype <= TY_TEMP_LO_LAST)
						k = K_TEMP_LO;
					else if (p.ptype >= TY_TEMP_HI_FIRST &&
							p.ptype <= TY_TEMP_HI_LAST)
						k = K_TEMP_HI;
					else if (p.ptype == TY_TEMP_FINE_A)
						k = K_TEMP_A;
					else if (p.ptype == TY_TEMP_FINE_B)
						k = K_TEMP_B;
				end
				FN_TEMP_HUM: begin
					if (p.ptype == 7'h01) k = K_TH1;
					else if (p.ptype == 7'h02) k = K_TH2;
					else if (p.ptype == 7'h03) k = K_TH3;
				end
				FN_PRESSURE: if (p.ptype == 7'h01) k = K_PRESS;
				FN_LIGHT: begin
					if (p.ptype == 7'h01) k = K_LIGHT1;
					else if (p.ptype == 7'h04) k = K_LIGHT4;
				end
				FN_OCCUPANCY: begin
					if (p.ptype == 7'h01) k = K_OCC1;
					else if (p.ptype == 7'h02) k = K_OCC2;
				end
				default: k = K_NONE;
			endcase
		end
		return k;
	endfunction

	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wire rst_n = rst_sync_q;

	wire decode_kind_t kind = kind_of(equipment_profile);
	wire [7:0] db3 = tel.data[31:24];
	wire [7:0] db2 = tel.data[23:16];
	wire [7:0] db1 = tel.data[15:8];
	wire [7:0] first_payload_byte = tel.data[7:0];
	wire [9:0] raw10_lo = {db2[1:0], db1};
	wire [9:0] raw10_hi = {db3[1:0], db2};
	wire four_byte = equipment_profile.org == ORG_FOUR_BYTE;
	// On four-byte profiles a cleared learn bit marks a teach-in telegram, which carries no reading
	wire teach_in = four_byte && !first_payload_byte[LEARN_BIT];
	wire org_match = tel.org == equipment_profile.org;
	wire accept = tel_valid && org_match && kind != K_NONE && !teach_in; // [R1]
	wire is_contact = kind == K_CONTACT;
	wire rd_clear = rd_en && rd_idx == SLOT_IDX_ONE;
	wire logic signed [31:0] temp_min = (kind == K_TEMP_LO) ?
		TEMP_LO_BASE +
		TEMP_STEP * int'(equipment_profile.ptype - TY_TEMP_LO_FIRST) :
		TEMP_HI_BASE +
		TEMP_STEP * int'(equipment_profile.ptype - TY_TEMP_HI_FIRST);

	logic [15:0] slot_q [NUM_SLOTS];
	logic [15:0] dec [NUM_SLOTS];
	logic [NUM_SLOTS-1:0] wr_mask;
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;

	// Values are signed; lin() truncates an int, so negatives land as
	// 16-bit two's complement without extra logic.
	always_comb begin
		for (int i = 0; i < NUM_SLOTS; i++) dec[i] = SLOT_RESET;
		wr_mask = '0;
		unique case (kind)
			K_CONTACT: begin
				dec[0] = {15'h0, first_payload_byte[0]}; // [R2]
				for (int i = 1; i < 5; i++) dec[i] = slot_q[i-1]; // [R3]
				wr_mask = 6'h1f;
			end
			K_RAW: begin
				dec[0] = {8'h00, first_payload_byte};
				wr_mask = 6'h01;
			end
			K_TEMP_LO: begin
				dec[0] = lin(temp_min, FULL_8 - int'(db1), TEMP_LO_SPAN,
					FULL_8); // [R5] [R16]
				wr_mask = 6'h01;
			end
			K_TEMP_HI: begin
				dec[0] = lin(temp_min, FULL_8 - int'(db1), TEMP_HI_SPAN,
					FULL_8); // [R5]
				wr_mask = 6'h01;
			end
			K_TEMP_A: begin
				dec[0] = lin(TEMP_A_BASE, FULL_10 - int'(raw10_lo), TEMP_A_SPAN,
					FULL_10); // [R6]
				wr_mask = 6'h01;
			end
			K_TEMP_B: begin
				dec[0] = lin(TEMP_B_BASE, FULL_10 - int'(raw10_lo), TEMP_B_SPAN,
					FULL_10); // [R6]
				wr_mask = 6'h01;
			end
			K_TH1, K_TH2: begin
				dec[0] = (kind == K_TH1) ?
					lin(0, int'(db1), TH1_SPAN, FULL_250) :
					lin(TH2_BASE, int'(db1), TH_SPAN, FULL_250); // [R7]
				dec[1] = lin(0, int'(db2), HUM_SPAN, FULL_250); // [R7]
				dec[2] = {15'h0, first_payload_byte[1]}; // [R8]
				wr_mask = 6'h07;
			end
			K_TH3: begin
				dec[0] = lin(TH2_BASE, int'(raw10_lo), TH_SPAN, FULL_10); // [R9]
				dec[1] = lin(0, int'(db3), HUM_SPAN, FULL_8); // [R7]
				dec[2] = {15'h0, first_payload_byte[0]}; // [R9]
				wr_mask = 6'h07;
			end
			K_PRESS: begin
				dec[0] = lin(PRESS_BASE, int'(raw10_hi), PRESS_SPAN,
					FULL_10); // [R10]
				dec[1] = {15'h0, first_payload_byte[0]}; // [R10]
				dec[2] = {15'h0, first_payload_byte[1]}; // [R10]
				wr_mask = 6'h07;
			end
			K_LIGHT1: begin
				dec[0] = lin(0, int'(db3), VOLT100_SPAN, FULL_8); // [R11]
				dec[1] = first_payload_byte[0] ?
					lin(LUX_LO_BASE, int'(db1), LUX_LO_SPAN, FULL_8) :
					lin(LUX_HI_BASE, int'(db2), LUX_HI_SPAN, FULL_8); // [R11]
				dec[2] = {15'h0, first_payload_byte[0]}; // [R11]
				wr_mask = 6'h07;
			end
			K_LIGHT4: begin
				dec[0] = lin(TH2_BASE, int'(db3), TH_SPAN, FULL_8); // [R12]
				dec[1] = lin(0, int'({db2, db1}), 1, LUX_DIV); // [R12]
				dec[2] = lin(0, int'(first_payload_byte[7:4]), STORE_SPAN,
					FULL_4); // [R12]
				dec[3] = {15'h0, first_payload_byte[1]}; // [R13]
				dec[4] = {15'h0, first_payload_byte[0]}; // [R13]
				wr_mask = 6'h1f;
			end
			K_OCC1: begin
				dec[0] = {15'h0, db1[7]}; // [R14]
				dec[1] = lin(0, int'(db3), VOLT10_SPAN, FULL_250); // [R14]
				dec[2] = {15'h0, first_payload_byte[0]}; // [R14]
				wr_mask = 6'h07;
			end
			K_OCC2: begin
				dec[0] = {15'h0, first_payload_byte[7]}; // [R15]
				wr_mask = 6'h01;
			end
			K_NONE: wr_mask = '0;
		endcase
	end

	// A telegram landing in the same cycle as the clearing read still counts
	always_comb begin
		cnt_d = rd_clear ? 3'h0 : cnt_q;
		if (accept && is_contact && cnt_d != MSG_COUNT_MAX)
			cnt_d = cnt_d + 3'h1; // [R4]
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_SLOTS; i++) slot_q[i] <= SLOT_RESET;
		end else if (accept) begin
			for (int i = 0; i < NUM_SLOTS; i++)
				if (wr_mask[i]) slot_q[i] <= dec[i];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) cnt_q <= 3'h0;
		else cnt_q <= cnt_d;
	end

	// Slot six shows the live count while the contact profile is selected.
	// Slots keep stale values after a profile change until a telegram of the new profile writes them.
	wire idx_ok = rd_idx <= SLOT_IDX_SIX;
	wire [15:0] rd_word = !idx_ok ? 16'h0000 :
		(is_contact && rd_idx == SLOT_IDX_SIX) ? {13'h0, cnt_q} : // [R4]
		slot_q[rd_idx];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_q <= 16'h0000;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_en;
			if (rd_en) rd_data_q <= rd_word;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_org_mismatch_hold: assert property ( // [R1]
		tel_valid && !org_match |=> slot_q[0] == $past(slot_q[0]))
		else $error("slot one changed on a foreign telegram");
	chk_contact_state: assert property ( // [R2]
		accept && is_contact |=> slot_q[0] == {15'h0, $past(tel.data[0])})
		else $error("contact state not loaded");
	chk_contact_shift: assert property ( // [R3]
		accept && is_contact |=> slot_q[1] == $past(slot_q[0]) &&
			slot_q[4] == $past(slot_q[3]))
		else $error("contact history did not shift");
	chk_count_sat: assert property ( // [R4]
		cnt_q <= MSG_COUNT_MAX)
		else $error("message count above five");
	chk_count_clear: assert property ( // [R4]
		rd_clear && !accept ##1 !accept |=> cnt_q == 3'h0)
		else $error("count not cleared by slot one read");
	chk_temp_min: assert property ( // [R5]
		accept && kind == K_TEMP_LO && db1 == 8'hff |=>
			slot_q[0] == 16'($past(temp_min)))
		else $error("temperature low end wrong");
	chk_fine_ends: assert property ( // [R6]
		accept && kind == K_TEMP_B && raw10_lo == 10'h000 |=>
			slot_q[0] == 16'h026f)
		else $error("fine temperature top end wrong");
	chk_hum_full: assert property ( // [R7]
		accept && kind == K_TH1 && db2 == 8'hfa |=> slot_q[1] == 16'h03e8)
		else $error("humidity full scale wrong");
	chk_press_top: assert property ( // [R10]
		accept && kind == K_PRESS && raw10_hi == 10'h3ff |=>
			slot_q[0] == 16'h047e)
		else $error("pressure top end wrong");
	chk_occ_motion: assert property ( // [R15]
		accept && kind == K_OCC2 |=>
			slot_q[0] == {15'h0, $past(first_payload_byte[7])})
		else $error("motion flag wrong");
	chk_read_answer: assert property (
		rd_en |=> rd_valid_q ##1 (rd_valid_q == $past(rd_en)))
		else $error("read answer timing wrong");
	chk_read_unmapped: assert property (
		rd_en && !idx_ok |=> rd_data_q == 16'h0000)
		else $error("unmapped slot read not zero");

	cov_contact: cover property (accept && is_contact);
	cov_count_full: cover property (cnt_q == MSG_COUNT_MAX);
	cov_clear_and_set: cover property (rd_clear && accept && is_contact);
	cov_light4: cover property (accept && kind == K_LIGHT4);

endmodule

/* File: sensor_model.sv */
// Stand-in for a radio sensor that sends one telegram per call.
// Assumes the decoder samples tel only in the cycle tel_valid is high.
`timescale 1ns/10ps
module sensor_model
	import radio_sensor_pkg::*;
(
	input wire logic core_clk,
	output logic tel_valid,
	output telegram_t tel
);
	initial begin
		tel_valid = 1'b0;
		tel = '0;
	end

	// Line is inverted after the strobe so stale data can never pass
	task send(input logic [7:0] o, input logic [31:0] d);
		@(posedge core_clk);
		tel_valid <= 1'b1;
		tel <= {o, d};
		@(posedge core_clk);
		tel_valid <= 1'b0;
		tel <= ~{o, d};
	endtask
endmodule

/* File: tb.sv */
// Self-checking bench: telegrams in, value slots read back and compared.
// Assumes the sensor model is the only telegram source.
`timescale 1ns/10ps
module tb
	import radio_sensor_pkg::*;
;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic tel_valid;
	telegram_t tel;
	equipment_profile_t ep = '0;
	logic rd_en = 1'b0;
	logic [2:0] rd_idx = 3'h0;
	logic [15:0] rd_data_q;
	logic rd_valid_q;
	logic st [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
	int failures = 0;
	int compares = 0;

	always #50 core_clk = ~core_clk;

	radio_sensor_value_decoder uut (
		.core_clk(core_clk),
		.rstn(rstn),
		.tel_valid(tel_valid),
		.tel(tel),
		.equipment_profile(ep),
		.rd_en(rd_en),
		.rd_idx(rd_idx),
		.rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q)
	);

	sensor_model sensor (
		.core_clk(core_clk),
		.tel_valid(tel_valid),
		.tel(tel)
	);

	task test_done();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One read strobe; answer is due exactly one cycle later
	task chk(input logic [2:0] idx, input logic [15:0] exp);
		@(posedge core_clk);
		rd_en <= 1'b1;
		rd_idx <= idx;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1;
		compares++;
		if (rd_valid_q !== 1'b1 || rd_data_q !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, rd_data_q, exp);
		end
	endtask

	task prof(input logic [7:0] o, input logic [5:0] f, input logic [6:0] t);
		@(posedge core_clk);
		ep <= {o, f, t};
	endtask

	initial begin
		#2000000;
		failures++;
		test_done();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		prof(ORG_ONE_BYTE, FN_CONTACT, 7'h01);
		foreach (st[i]) sensor.send(ORG_ONE_BYTE, {31'h0, st[i]});
		chk(SLOT_IDX_SIX, 16'h0005);
		chk(3'h1, 16'h0000);
		chk(3'h2, 16'h0001);
		chk(3'h3, 16'h0001);
		chk(3'h4, 16'h0000);
		chk(SLOT_IDX_ONE, 16'h0001);
		chk(SLOT_IDX_SIX, 16'h0000);
		sensor.send(ORG_FOUR_BYTE, 32'h0000_0008);
		chk(SLOT_IDX_SIX, 16'h0000);
		chk(SLOT_IDX_ONE, 16'h0001);
		sensor.send(ORG_ONE_BYTE, 32'h0000_0000);
		// Slot six first: reading slot one clears the count
		chk(SLOT_IDX_SIX, 16'h0001);
		chk(SLOT_IDX_ONE, 16'h0000);
		chk(3'h1, 16'h0001);
		chk(3'h6, 16'h0000);
		prof(ORG_ONE_BYTE, FN_UNIVERSAL, TY_UNIVERSAL);
		sensor.send(ORG_ONE_BYTE, 32'h0000_00a5);
		chk(SLOT_IDX_ONE, 16'h00a5);
		$display("test contact done");
		prof(ORG_FOUR_BYTE, FN_TEMP, TY_TEMP_LO_FIRST);
		sensor.send(ORG_FOUR_BYTE, 32'h0000_ff08);
		chk(SLOT_IDX_ONE, 16'hfe70);
		prof(ORG_FOUR_BYTE, FN_TEMP, TY_TEMP_HI_FIRST);
		sensor.send(ORG_FOUR_BYTE, 32'h0000_ff08);
		chk(SLOT_IDX_ONE, 16'hfda8);
		prof(ORG_FOUR_BYTE, FN_TEMP, TY_TEMP_FINE_A);
		sensor.send(ORG_FOUR_BYTE, 32'h0000_0008);
		chk(SLOT_IDX_ONE, 16'h019c);
		prof(ORG_FOUR_BYTE, FN_TEMP, TY_TEMP_FINE_B);
		sensor.send(ORG_FOUR_BYTE, 32'h0000_0008);
		chk(SLOT_IDX_ONE, 16'h026f);
		$display("test temperature done");
		prof(ORG_FOUR_BYTE, FN_TEMP_HUM, 7'h01);
		sensor.send(ORG_FOUR_BYTE, 32'h007d_7d0a);
		chk(SLOT_IDX_ONE, 16'h00c8);
		chk(3'h1, 16'h01f4);
		chk(3'h2, 16'h0001);
		// Teach-in telegram must leave every slot alone
		sensor.send(ORG_FOUR_BYTE, 32'h00fa_fa00);
		chk(SLOT_IDX_ONE, 16'h00c8);
		prof(ORG_FOUR_BYTE, FN_TEMP_HUM, 7'h02);
		sensor.send(ORG_FOUR_BYTE, 32'h0000_0008);
		chk(SLOT_IDX_ONE, 16'hff38);
		chk(3'h2, 16'h0000);
		prof(ORG_FOUR_BYTE, FN_TEMP_HUM, 7'h03);
		sensor.send(ORG_FOUR_BYTE, 32'hff03_ff09);
		chk(SLOT_IDX_ONE, 16'h0258);
		chk(3'h1, 16'h03e8);
		chk(3'h2, 16'h0001);
		prof(ORG_FOUR_BYTE, FN_PRESSURE, 7'h01);
		sensor.send(ORG_FOUR_BYTE, 32'h03ff_0009);
		chk(SLOT_IDX_ONE, 16'h047e);
		chk(3'h1, 16'h0001);
		chk(3'h2, 16'h0000);
		$display("test climate done");
		prof(ORG_FOUR_BYTE, FN_LIGHT, 7'h01);
		sensor.send(ORG_FOUR_BYTE, 32'hff00_ff09);
		chk(SLOT_IDX_ONE, 16'h01fe);
		chk(3'h1, 16'h0bb8);
		chk(3'h2, 16'h0001);
		prof(ORG_FOUR_BYTE, FN_LIGHT, 7'h04);
		sensor.send(ORG_FOUR_BYTE, 32'h00ff_fffa);
		chk(3'h1, 16'h1999);
		chk(3'h2, 16'h0064);
		chk(3'h3, 16'h0001);
		chk(3'h4, 16'h0000);
		prof(ORG_FOUR_BYTE, FN_OCCUPANCY, 7'h01);
		sensor.send(ORG_FOUR_BYTE, 32'hfa00_8009);
		chk(SLOT_IDX_ONE, 16'h0001);
		chk(3'h1, 16'h0032);
		chk(3'h2, 16'h0001);
		prof(ORG_FOUR_BYTE, FN_OCCUPANCY, 7'h02);
		sensor.send(ORG_FOUR_BYTE, 32'h0000_0088);
		chk(SLOT_IDX_ONE, 16'h0001);
		sensor.send(ORG_FOUR_BYTE, 32'h0000_0008);
		chk(SLOT_IDX_ONE, 16'h0000);
		$display("test light and occupancy done");
		test_done();
	end
endmodule
